// [shared/status_pkg.sv]
package status_pkg;

    // =========================================
    // Widths and set indices
    localparam int REG_W = 16;
    localparam int NUM_SETS = 8;
    localparam int LIMIT_POINTS = 6;
    localparam logic [2:0] SET_DEVICE = 3'h0;
    localparam logic [2:0] SET_OPERATION = 3'h1;
    localparam logic [2:0] SET_CALIBRATING = 3'h2;
    localparam logic [2:0] SET_LOWER_LIMIT = 3'h3;
    localparam logic [2:0] SET_MEASURING = 3'h4;
    localparam logic [2:0] SET_SENSOR_MEMORY = 3'h5;
    localparam logic [2:0] SET_TRIGGER = 3'h6;
    localparam logic [2:0] SET_UPPER_LIMIT = 3'h7;

    // =========================================
    // Bit positions
    localparam int BIT_CHAN_A = 1;
    localparam int BIT_FAULT_A = 3;
    localparam int BIT_KEY_PRESS = 14;
    localparam int BIT_OP_CAL = 0;
    localparam int BIT_OP_MEAS = 4;
    localparam int BIT_OP_TRIG = 5;
    localparam int BIT_OP_SENSOR_MEM = 10;
    localparam int BIT_OP_LOWER_LIMIT = 11;
    localparam int BIT_OP_UPPER_LIMIT = 12;

    // =========================================
    // Masks and preset values
    localparam logic [15:0] WRITE_MASK = 16'h7fff;
    localparam logic [15:0] MASK_DEVICE = 16'h401e;
    localparam logic [15:0] MASK_OPERATION = 16'h1c31;
    localparam logic [15:0] MASK_CHANNELS = 16'h0006;
    localparam logic [15:0] MASK_LIMIT = 16'h007e;
    localparam logic [15:0] MASK_CHAN_B_BITS = 16'h0014;
    localparam logic [15:0] MASK_LIMIT_CHAN_B = 16'h0004;
    localparam logic [15:0] PRESET_ONES = 16'h7fff;
    localparam logic [15:0] PRESET_ZEROS = 16'h0000;

    // =========================================
    // Command codes
    typedef enum logic [3:0] {
        OP_COND_READ = 4'h0,
        OP_EVENT_READ = 4'h1,
        OP_ENABLE_WRITE = 4'h2,
        OP_ENABLE_READ = 4'h3,
        OP_RISE_WRITE = 4'h4,
        OP_RISE_READ = 4'h5,
        OP_FALL_WRITE = 4'h6,
        OP_FALL_READ = 4'h7,
        OP_CLEAR_STATUS = 4'h8,
        OP_PRESET = 4'h9,
        OP_GENERAL_RESET = 4'ha
    } status_op_e;

endpackage

// [design/status_register_set.sv]
`timescale 1ns/1ps
module status_register_set
    import status_pkg::*;
#(
    parameter logic [15:0] USED_MASK = 16'h7fff,
    parameter logic [15:0] ENABLE_PRESET = 16'h7fff
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Hardware inputs
    input wire logic [15:0] i_cond,
    input wire logic [15:0] i_direct_evt,
    // Software controls
    input wire logic [15:0] i_wdata,
    input wire logic i_enable_wr,
    input wire logic i_rise_wr,
    input wire logic i_fall_wr,
    input wire logic i_event_clear,
    input wire logic i_preset,
    // Register contents
    output logic [15:0] o_cond,
    output logic [15:0] o_event,
    output logic [15:0] o_enable,
    output logic [15:0] o_rise,
    output logic [15:0] o_fall,
    output logic o_summary
);

    // =========================================
    // Storage
    logic [15:0] prev_cond_ff;
    logic [15:0] event_ff;
    logic [15:0] enable_ff;
    logic [15:0] rise_ff;
    logic [15:0] fall_ff;

    wire [15:0] cond_w = i_cond & USED_MASK;
    wire [15:0] wmask_w = USED_MASK & WRITE_MASK;
    wire [15:0] rise_hit_w = cond_w & ~prev_cond_ff & rise_ff;
    wire [15:0] fall_hit_w = ~cond_w & prev_cond_ff & fall_ff;
    wire [15:0] set_w = (rise_hit_w | fall_hit_w | i_direct_evt) & wmask_w;
    wire [15:0] kept_w = i_event_clear ? PRESET_ZEROS : event_ff;
    wire [15:0] nxt_event = kept_w | set_w;
    wire [15:0] nxt_enable = i_preset ? (ENABLE_PRESET & wmask_w) : (i_wdata & wmask_w);
    wire [15:0] nxt_rise = i_preset ? (PRESET_ONES & wmask_w) : (i_wdata & wmask_w);
    wire [15:0] nxt_fall = i_preset ? PRESET_ZEROS : (i_wdata & wmask_w);

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            prev_cond_ff <= PRESET_ZEROS;
            event_ff <= PRESET_ZEROS;
            enable_ff <= ENABLE_PRESET & wmask_w;
            rise_ff <= PRESET_ONES & wmask_w;
            fall_ff <= PRESET_ZEROS;
        end else begin
            prev_cond_ff <= cond_w;
            event_ff <= nxt_event;
            if (i_enable_wr || i_preset) begin
                enable_ff <= nxt_enable;
            end
            if (i_rise_wr || i_preset) begin
                rise_ff <= nxt_rise;
            end
            if (i_fall_wr || i_preset) begin
                fall_ff <= nxt_fall;
            end
        end
    end

    assign o_cond = cond_w & WRITE_MASK;
    assign o_event = event_ff;
    assign o_enable = enable_ff;
    assign o_rise = rise_ff;
    assign o_fall = fall_ff;
    assign o_summary = |(event_ff & enable_ff);

endmodule // status_register_set

// [design/limit_fail_tracker.sv]
`timescale 1ns/1ps
module limit_fail_tracker
    import status_pkg::*;
#(
    parameter int POINTS = LIMIT_POINTS
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Per point test results
    input wire logic [POINTS-1:0] i_test_fail,
    input wire logic [POINTS-1:0] i_meas_done,
    input wire logic [POINTS-1:0] i_test_enabled,
    // Failure flags
    output logic [POINTS-1:0] o_fail
);

    // =========================================
    // One sticky flag per channel or window
    logic [POINTS-1:0] fail_ff;
    logic [POINTS-1:0] nxt_fail;

    genvar g;
    generate
        for (g = 0; g < POINTS; g++) begin : g_point
            wire pass_w = i_meas_done[g] && i_test_enabled[g] && !i_test_fail[g];
            assign nxt_fail[g] = i_test_fail[g] ? 1'b1 : (pass_w ? 1'b0 : fail_ff[g]);
        end
    endgenerate

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            fail_ff <= '0;
        end else begin
            fail_ff <= nxt_fail;
        end
    end

    assign o_fail = fail_ff;

endmodule // limit_fail_tracker

// [design/instrument_status_registers.sv]
`timescale 1ns/1ps
module instrument_status_registers
    import status_pkg::*;
#(
    parameter int NUM_CHANNELS = 2
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Command port
    input wire logic i_cmd_valid,
    input wire logic [3:0] i_cmd_op,
    input wire logic [2:0] i_cmd_set,
    input wire logic [15:0] i_cmd_wdata,
    // Sensor events
    input wire logic [1:0] i_sensor_attached,
    input wire logic [1:0] i_sensor_mem_fail,
    input wire logic [1:0] i_sensor_both_inputs,
    input wire logic [1:0] i_sensor_mem_reading,
    input wire logic i_key_press,
    // Calibration, measurement and trigger
    input wire logic [1:0] i_cal_start,
    input wire logic i_cal_all_start,
    input wire logic [1:0] i_cal_end,
    input wire logic [1:0] i_measuring,
    input wire logic [1:0] i_wait_trigger,
    // Limit tests
    input wire logic [5:0] i_meas_done,
    input wire logic [5:0] i_lower_test_fail,
    input wire logic [5:0] i_lower_test_enabled,
    input wire logic [5:0] i_upper_test_fail,
    input wire logic [5:0] i_upper_test_enabled,
    // Response
    output logic o_rsp_valid,
    output logic [15:0] o_rsp_data,
    output logic o_operation_summary
);

    // =========================================
    // Channel presence
    localparam logic [15:0] CHAN_DROP = (NUM_CHANNELS > 1) ? PRESET_ZEROS : MASK_CHAN_B_BITS;
    localparam logic [15:0] LIMIT_DROP = (NUM_CHANNELS > 1) ? PRESET_ZEROS : MASK_LIMIT_CHAN_B;
    localparam logic [15:0] DEV_MASK = MASK_DEVICE & ~CHAN_DROP;
    localparam logic [15:0] CH_MASK = MASK_CHANNELS & ~LIMIT_DROP;
    localparam logic [15:0] LIM_MASK = MASK_LIMIT & ~LIMIT_DROP;

    // =========================================
    // Command decode
    wire cmd_cond_rd = i_cmd_valid && (i_cmd_op == OP_COND_READ);
    wire cmd_evt_rd = i_cmd_valid && (i_cmd_op == OP_EVENT_READ);
    wire cmd_en_wr = i_cmd_valid && (i_cmd_op == OP_ENABLE_WRITE);
    wire cmd_en_rd = i_cmd_valid && (i_cmd_op == OP_ENABLE_READ);
    wire cmd_rise_wr = i_cmd_valid && (i_cmd_op == OP_RISE_WRITE);
    wire cmd_rise_rd = i_cmd_valid && (i_cmd_op == OP_RISE_READ);
    wire cmd_fall_wr = i_cmd_valid && (i_cmd_op == OP_FALL_WRITE);
    wire cmd_fall_rd = i_cmd_valid && (i_cmd_op == OP_FALL_READ);
    wire cmd_clear = i_cmd_valid && (i_cmd_op == OP_CLEAR_STATUS);
    wire cmd_preset = i_cmd_valid && (i_cmd_op == OP_PRESET);
    wire cmd_read = cmd_cond_rd | cmd_evt_rd | cmd_en_rd | cmd_rise_rd | cmd_fall_rd;

    // =========================================
    // Calibrating flags
    logic [1:0] cal_ff;
    wire [1:0] cal_begin_w = i_cal_start | {2{i_cal_all_start}};
    wire [1:0] nxt_cal = cal_begin_w | (cal_ff & ~i_cal_end);

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            cal_ff <= 2'h0;
        end else begin
            cal_ff <= nxt_cal;
        end
    end

    // =========================================
    // Limit trackers
    logic [5:0] lower_fail;
    logic [5:0] upper_fail;

    limit_fail_tracker #(.POINTS(LIMIT_POINTS)) u_lower (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_test_fail(i_lower_test_fail),
        .i_meas_done(i_meas_done),
        .i_test_enabled(i_lower_test_enabled),
        .o_fail(lower_fail)
    );

    limit_fail_tracker #(.POINTS(LIMIT_POINTS)) u_upper (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_test_fail(i_upper_test_fail),
        .i_meas_done(i_meas_done),
        .i_test_enabled(i_upper_test_enabled),
        .o_fail(upper_fail)
    );

    // =========================================
    // Condition vectors
    logic [15:0] cond_in [NUM_SETS];
    logic [15:0] direct_in [NUM_SETS];
    logic [15:0] cond_q [NUM_SETS];
    logic [15:0] event_q [NUM_SETS];
    logic [15:0] enable_q [NUM_SETS];
    logic [15:0] rise_q [NUM_SETS];
    logic [15:0] fall_q [NUM_SETS];
    logic [NUM_SETS-1:0] summary;

    wire [1:0] fault_w = i_sensor_mem_fail | i_sensor_both_inputs;
    wire [15:0] op_cond_w = (16'(summary[SET_CALIBRATING]) << BIT_OP_CAL)
        | (16'(summary[SET_MEASURING]) << BIT_OP_MEAS)
        | (16'(summary[SET_TRIGGER]) << BIT_OP_TRIG);
    wire [15:0] op_cond_hi_w = (16'(summary[SET_SENSOR_MEMORY]) << BIT_OP_SENSOR_MEM)
        | (16'(summary[SET_LOWER_LIMIT]) << BIT_OP_LOWER_LIMIT)
        | (16'(summary[SET_UPPER_LIMIT]) << BIT_OP_UPPER_LIMIT);

    assign cond_in[SET_DEVICE] = (16'(i_sensor_attached) << BIT_CHAN_A)
        | (16'(fault_w) << BIT_FAULT_A);
    assign cond_in[SET_OPERATION] = op_cond_w | op_cond_hi_w;
    assign cond_in[SET_CALIBRATING] = 16'(cal_ff) << BIT_CHAN_A;
    assign cond_in[SET_LOWER_LIMIT] = 16'(lower_fail) << BIT_CHAN_A;
    assign cond_in[SET_MEASURING] = 16'(i_measuring) << BIT_CHAN_A;
    assign cond_in[SET_SENSOR_MEMORY] = 16'(i_sensor_mem_reading) << BIT_CHAN_A;
    assign cond_in[SET_TRIGGER] = 16'(i_wait_trigger) << BIT_CHAN_A;
    assign cond_in[SET_UPPER_LIMIT] = 16'(upper_fail) << BIT_CHAN_A;

    assign direct_in[SET_DEVICE] = 16'(i_key_press) << BIT_KEY_PRESS;
    assign direct_in[SET_OPERATION] = PRESET_ZEROS;
    assign direct_in[SET_CALIBRATING] = PRESET_ZEROS;
    assign direct_in[SET_LOWER_LIMIT] = PRESET_ZEROS;
    assign direct_in[SET_MEASURING] = PRESET_ZEROS;
    assign direct_in[SET_SENSOR_MEMORY] = PRESET_ZEROS;
    assign direct_in[SET_TRIGGER] = PRESET_ZEROS;
    assign direct_in[SET_UPPER_LIMIT] = PRESET_ZEROS;

    // =========================================
    // Register sets
    genvar s;
    generate
        for (s = 0; s < NUM_SETS; s++) begin : g_set
            localparam logic [15:0] USED = (s == SET_DEVICE) ? DEV_MASK
                : (s == SET_OPERATION) ? MASK_OPERATION
                : ((s == SET_LOWER_LIMIT) || (s == SET_UPPER_LIMIT)) ? LIM_MASK
                : CH_MASK;
            localparam logic [15:0] EN_PRESET = (s == SET_OPERATION) ? PRESET_ZEROS : PRESET_ONES;
            wire hit_w = (i_cmd_set == 3'(s));
            status_register_set #(
                .USED_MASK(USED),
                .ENABLE_PRESET(EN_PRESET)
            ) u_set (
                .i_clock(i_clock),
                .i_sys_rst(i_sys_rst),
                .i_cond(cond_in[s]),
                .i_direct_evt(direct_in[s]),
                .i_wdata(i_cmd_wdata),
                .i_enable_wr(cmd_en_wr && hit_w),
                .i_rise_wr(cmd_rise_wr && hit_w),
                .i_fall_wr(cmd_fall_wr && hit_w),
                .i_event_clear(cmd_clear || (cmd_evt_rd && hit_w)),
                .i_preset(cmd_preset),
                .o_cond(cond_q[s]),
                .o_event(event_q[s]),
                .o_enable(enable_q[s]),
                .o_rise(rise_q[s]),
                .o_fall(fall_q[s]),
                .o_summary(summary[s])
            );
        end
    endgenerate

    // =========================================
    // Read selection
    wire [15:0] rd_data_w = cmd_cond_rd ? cond_q[i_cmd_set]
        : cmd_evt_rd ? event_q[i_cmd_set]
        : cmd_en_rd ? enable_q[i_cmd_set]
        : cmd_rise_rd ? rise_q[i_cmd_set]
        : fall_q[i_cmd_set];
    wire [15:0] nxt_rsp_data = cmd_read ? (rd_data_w & WRITE_MASK) : o_rsp_data;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_rsp_valid <= 1'b0;
            o_rsp_data <= PRESET_ZEROS;
            o_operation_summary <= 1'b0;
        end else begin
            o_rsp_valid <= cmd_read;
            o_rsp_data <= nxt_rsp_data;
            o_operation_summary <= summary[SET_OPERATION];
        end
    end

endmodule // instrument_status_registers

// [bench/instrument_status_monitor.sv]
`timescale 1ns/1ps
module instrument_status_monitor
    import status_pkg::*;
#(
    parameter int NUM_CHANNELS = 2
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Command port
    input wire logic i_cmd_valid,
    input wire logic [3:0] i_cmd_op,
    input wire logic [2:0] i_cmd_set,
    // Hardware levels
    input wire logic [1:0] i_sensor_attached,
    input wire logic [1:0] i_sensor_mem_fail,
    input wire logic [1:0] i_sensor_both_inputs,
    input wire logic [1:0] i_sensor_mem_reading,
    input wire logic i_key_press,
    input wire logic [1:0] i_measuring,
    input wire logic [1:0] i_wait_trigger,
    // Response
    input wire logic o_rsp_valid,
    input wire logic [15:0] o_rsp_data
);
    // ========================================
    // Decode and input history
    localparam logic [15:0] KEEP_DEV = (NUM_CHANNELS > 1) ? 16'hffff : ~MASK_CHAN_B_BITS;
    localparam logic [15:0] KEEP_CH = (NUM_CHANNELS > 1) ? 16'hffff : ~MASK_LIMIT_CHAN_B;
    logic [1:0] attached_ff;
    logic [1:0] fault_ff;
    wire logic [1:0] fault = i_sensor_mem_fail | i_sensor_both_inputs;
    wire logic cond_rd = i_cmd_valid && i_cmd_op == OP_COND_READ;
    wire logic is_read = cond_rd || (i_cmd_valid && !i_cmd_op[3] && i_cmd_op[0]);
    wire logic dev_evt_rd = i_cmd_valid && i_cmd_op == OP_EVENT_READ && i_cmd_set == SET_DEVICE;
    wire logic quiet = attached_ff == i_sensor_attached && fault_ff == fault && !i_key_press;

    always_ff @(posedge i_clock) begin
        attached_ff <= i_sensor_attached;
        fault_ff <= fault;
    end

    // ========================================
    // Properties
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    a_read_answer: assert property (is_read |=> o_rsp_valid)
        else $error("read got no response");
    a_no_extra_answer: assert property (!is_read |=> !o_rsp_valid)
        else $error("response without read");
    a_bit15_low: assert property (o_rsp_valid |-> !o_rsp_data[15])
        else $error("bit 15 set in response");
    a_device_cond: assert property (cond_rd && i_cmd_set == SET_DEVICE
        && !$past(i_sys_rst) && $stable(i_sensor_attached) && $stable(fault) |=> o_rsp_data
        == (KEEP_DEV & {11'h000, $past(fault), $past(i_sensor_attached), 1'b0}))
        else $error("device condition mismatch");
    a_measuring_cond: assert property (cond_rd && i_cmd_set == SET_MEASURING
        && !$past(i_sys_rst) && $stable(i_measuring)
        |=> o_rsp_data == (KEEP_CH & {13'h0000, $past(i_measuring), 1'b0}))
        else $error("measuring condition mismatch");
    a_memory_cond: assert property (cond_rd && i_cmd_set == SET_SENSOR_MEMORY
        && !$past(i_sys_rst) && $stable(i_sensor_mem_reading)
        |=> o_rsp_data == (KEEP_CH & {13'h0000, $past(i_sensor_mem_reading), 1'b0}))
        else $error("sensor memory condition mismatch");
    a_trigger_cond: assert property (cond_rd && i_cmd_set == SET_TRIGGER
        && !$past(i_sys_rst) && $stable(i_wait_trigger)
        |=> o_rsp_data == (KEEP_CH & {13'h0000, $past(i_wait_trigger), 1'b0}))
        else $error("trigger condition mismatch");
    a_event_clears: assert property (quiet ##1 (dev_evt_rd && quiet)
        ##1 (dev_evt_rd && quiet) |=> o_rsp_data == 16'h0000)
        else $error("device event not cleared by read");
endmodule // instrument_status_monitor

bind instrument_status_registers instrument_status_monitor #(.NUM_CHANNELS(NUM_CHANNELS))
    instrument_status_monitor_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op), .i_cmd_set(i_cmd_set),
    .i_sensor_attached(i_sensor_attached), .i_sensor_mem_fail(i_sensor_mem_fail),
    .i_sensor_both_inputs(i_sensor_both_inputs), .i_sensor_mem_reading(i_sensor_mem_reading),
    .i_key_press(i_key_press), .i_measuring(i_measuring), .i_wait_trigger(i_wait_trigger),
    .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data));

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
    import status_pkg::*;
    // ========================================
    // Signals
    logic i_clock, i_sys_rst, i_cmd_valid, i_key_press, i_cal_all_start;
    logic o_rsp_valid, o_operation_summary;
    logic [3:0] i_cmd_op;
    logic [2:0] i_cmd_set;
    logic [15:0] i_cmd_wdata, o_rsp_data, val;
    logic [1:0] i_sensor_attached, i_sensor_mem_fail, i_sensor_both_inputs, i_sensor_mem_reading;
    logic [1:0] i_cal_start, i_cal_end, i_measuring, i_wait_trigger;
    logic [5:0] i_meas_done, i_lower_test_fail, i_lower_test_enabled;
    logic [5:0] i_upper_test_fail, i_upper_test_enabled, lo, up, lo_ev, up_ev;
    logic [31:0] seed;
    int errors, checks_done;

    instrument_status_registers #(.NUM_CHANNELS(2)) instrument_status_registers_inst (.*);

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    // ========================================
    // Helpers
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [15:0] used(input logic [2:0] s);
        case (s)
            SET_DEVICE: return MASK_DEVICE;
            SET_OPERATION: return MASK_OPERATION;
            SET_LOWER_LIMIT, SET_UPPER_LIMIT: return MASK_LIMIT;
            default: return MASK_CHANNELS;
        endcase
    endfunction
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic send(input logic [3:0] op, input logic [2:0] set, input logic [15:0] d);
        i_cmd_valid = 1'b1;
        i_cmd_op = op;
        i_cmd_set = set;
        i_cmd_wdata = d;
        @(negedge i_clock);
    endtask
    task automatic rdc(input string name, input logic [3:0] op, input logic [2:0] set,
            input logic [15:0] exp);
        send(op, set, 16'h0000);
        chk("rsp_valid", 16'h0001, {15'h0000, o_rsp_valid});
        chk(name, exp, o_rsp_data);
    endtask
    task automatic idle(input int n);
        i_cmd_valid = 1'b0;
        repeat (n) @(negedge i_clock);
    endtask
    task automatic key_tap;
        i_key_press = 1'b1;
        idle(1);
        i_key_press = 1'b0;
        idle(1);
    endtask
    task automatic final_report;
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ========================================
    // Main sequence
    initial begin
        {i_cmd_valid, i_key_press, i_cal_all_start, i_cmd_op, i_cmd_set, i_cmd_wdata} = '0;
        {i_sensor_attached, i_sensor_mem_fail, i_sensor_both_inputs, i_sensor_mem_reading} = '0;
        {i_cal_start, i_cal_end, i_measuring, i_wait_trigger, i_meas_done} = '0;
        {i_lower_test_fail, i_lower_test_enabled, i_upper_test_fail, i_upper_test_enabled} = '0;
        {errors, checks_done} = '0;
        seed = 32'h0000_0046;
        i_sys_rst = 1'b1;
        repeat (8) @(negedge i_clock);
        i_sys_rst = 1'b0;
        for (int s = 0; s < 8; s++) begin
            rdc("enable_rst", OP_ENABLE_READ, 3'(s), (s == 1) ? 16'h0000 : used(3'(s)));
            rdc("rise_rst", OP_RISE_READ, 3'(s), used(3'(s)));
            rdc("fall_rst", OP_FALL_READ, 3'(s), 16'h0000);
            rdc("event_rst", OP_EVENT_READ, 3'(s), 16'h0000);
            for (int k = 0; k < 3; k++) begin
                seed = xorshift(seed);
                val = seed[15:0] | 16'h8000;
                send(4'(2 * k + 2), 3'(s), val);
                rdc("write_back", 4'(2 * k + 3), 3'(s), val & used(3'(s)));
            end
        end
        send(OP_PRESET, SET_DEVICE, 16'h0000);
        send(OP_ENABLE_WRITE, SET_OPERATION, 16'hffff);
        i_sensor_attached = 2'b01;
        idle(3);
        rdc("dev_cond", OP_COND_READ, SET_DEVICE, 16'h0002);
        rdc("dev_cond_again", OP_COND_READ, SET_DEVICE, 16'h0002);
        rdc("dev_event", OP_EVENT_READ, SET_DEVICE, 16'h0002);
        rdc("dev_event_clr", OP_EVENT_READ, SET_DEVICE, 16'h0000);
        send(OP_RISE_WRITE, SET_DEVICE, 16'h0000);
        send(OP_FALL_WRITE, SET_DEVICE, 16'h0006);
        i_sensor_attached = 2'b10;
        idle(3);
        rdc("fall_event", OP_EVENT_READ, SET_DEVICE, 16'h0002);
        key_tap();
        {i_sensor_mem_fail, i_sensor_both_inputs} = 4'h6;
        idle(3);
        rdc("key_event", OP_EVENT_READ, SET_DEVICE, 16'h4000);
        rdc("fault_cond", OP_COND_READ, SET_DEVICE, 16'h001c);
        {i_sensor_mem_fail, i_sensor_both_inputs} = 4'h0;
        key_tap();
        send(OP_GENERAL_RESET, SET_DEVICE, 16'h0000);
        rdc("kept_event", OP_EVENT_READ, SET_DEVICE, 16'h4000);
        rdc("clear_fault", OP_COND_READ, SET_DEVICE, 16'h0004);
        key_tap();
        send(OP_CLEAR_STATUS, SET_DEVICE, 16'h0000);
        rdc("cleared_event", OP_EVENT_READ, SET_DEVICE, 16'h0000);
        i_cal_start = 2'b01;
        idle(1);
        i_cal_start = 2'b00;
        idle(6);
        rdc("cal_cond", OP_COND_READ, SET_CALIBRATING, 16'h0002);
        rdc("op_cond_cal", OP_COND_READ, SET_OPERATION, 16'h0001);
        chk("op_summary", 16'h0001, {15'h0000, o_operation_summary});
        rdc("op_event_cal", OP_EVENT_READ, SET_OPERATION, 16'h0001);
        i_cal_end = 2'b01;
        idle(1);
        i_cal_end = 2'b00;
        idle(2);
        rdc("cal_end", OP_COND_READ, SET_CALIBRATING, 16'h0000);
        i_cal_all_start = 1'b1;
        idle(1);
        i_cal_all_start = 1'b0;
        idle(2);
        rdc("cal_all", OP_COND_READ, SET_CALIBRATING, 16'h0006);
        {i_measuring, i_wait_trigger, i_sensor_mem_reading} = 6'h39;
        idle(6);
        rdc("meas_cond", OP_COND_READ, SET_MEASURING, 16'h0006);
        rdc("trig_cond", OP_COND_READ, SET_TRIGGER, 16'h0004);
        rdc("mem_cond", OP_COND_READ, SET_SENSOR_MEMORY, 16'h0002);
        rdc("op_cond_all", OP_COND_READ, SET_OPERATION, 16'h0431);
        {i_measuring, i_wait_trigger, i_sensor_mem_reading} = 6'h00;
        idle(3);
        rdc("meas_end", OP_COND_READ, SET_MEASURING, 16'h0000);
        {lo, up, lo_ev, up_ev} = '0;
        for (int it = 0; it < 12; it++) begin
            seed = xorshift(seed);
            i_lower_test_fail = (it == 0) ? 6'h3f : (it < 3) ? 6'h00 : seed[5:0];
            i_upper_test_fail = (it < 3) ? i_lower_test_fail : seed[11:6];
            i_meas_done = (it == 0) ? 6'h00 : (it < 3) ? 6'h3f : seed[17:12];
            i_lower_test_enabled = (it == 1) ? 6'h00 : (it < 3) ? 6'h3f : seed[23:18];
            i_upper_test_enabled = (it < 3) ? i_lower_test_enabled : seed[29:24];
            lo = (lo & ~(i_meas_done & i_lower_test_enabled)) | i_lower_test_fail;
            up = (up & ~(i_meas_done & i_upper_test_enabled)) | i_upper_test_fail;
            lo_ev = lo_ev | lo;
            up_ev = up_ev | up;
            idle(1);
            {i_meas_done, i_lower_test_fail, i_upper_test_fail} = '0;
            idle(2);
            val = {9'h000, lo, 1'b0};
            rdc("lower_cond", OP_COND_READ, SET_LOWER_LIMIT, val);
            rdc("upper_cond", OP_COND_READ, SET_UPPER_LIMIT, {9'h000, up, 1'b0});
        end
        idle(4);
        val = 16'h0431 | {3'h0, |up_ev, |lo_ev, 11'h000};
        rdc("op_cond_limit", OP_COND_READ, SET_OPERATION, val);
        idle(1);
        final_report();
    end
endmodule // tb
